// >>> rtl/pci_primary_port.sv
// primary bus port: single data phase initiator, parity, perr, serr
// assumes every bus pin is synchronous to clk (the primary bus clock);
// wires are resolved outside from the output enables
`timescale 1ns/10ps
`default_nettype none
module pci_primary_port
	import pci_pri_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	// user side
	input wire logic reqValid,
	output logic reqReady,
	input wire logic reqWrite,
	input wire logic [CBE_W-1:0] reqCmd,
	input wire logic [AD_W-1:0] reqAddr,
	input wire logic [CBE_W-1:0] reqByteEnN,
	input wire logic [AD_W-1:0] reqData,
	output logic [AD_W-1:0] rdData,
	output logic rdValid,
	output logic xferDone,
	output logic masterAbort,
	output logic targetStop,
	output logic dataParityErr,
	output logic addrParityErr,
	output logic perrReported,
	input wire logic parityRespEn,
	input wire logic serrEnable,
	input wire logic [SERR_SRC_W-1:0] serrSrcEnable,
	input wire logic [SERR_SRC_W-1:1] serrExtEvent,
	// bus pins
	input wire logic [AD_W-1:0] adIn,
	output logic [AD_W-1:0] adOut,
	output logic adOe,
	input wire logic [CBE_W-1:0] cbeNIn,
	output logic [CBE_W-1:0] cbeNOut,
	output logic cbeNOe,
	input wire logic parIn,
	output logic parOut,
	output logic parOe,
	input wire logic frameNIn,
	output logic frameNOut,
	output logic frameNOe,
	input wire logic irdyNIn,
	output logic irdyNOut,
	output logic irdyNOe,
	input wire logic trdyNIn,
	input wire logic devselNIn,
	input wire logic stopNIn,
	input wire logic gntN,
	output logic reqN,
	input wire logic perrNIn,
	output logic perrNOut,
	output logic perrNOe,
	input wire logic serrNIn,
	output logic serrNOut,
	output logic serrNOe
);
	// ****************************************************************
	// declarations
	// ****************************************************************
	initState_t state;
	initState_t next_state;
	logic wrReg;
	logic [CBE_W-1:0] cmdReg;
	logic [CBE_W-1:0] beReg;
	logic [AD_W-1:0] addrReg;
	logic [AD_W-1:0] dataReg;
	logic firstData;
	logic [2:0] devselCnt;
	logic devselSeen;
	logic busIdle;
	logic parkNow;
	logic transfer;
	logic abortNow;
	logic stopNow;
	logic sampleData;
	logic sampleAddr;
	logic frameDly;
	logic perrAssert;
	logic perrHold;
	logic wrXfer1;
	logic wrXfer2;
	logic serrDrive;

	parity_check_if pc ();

	// ****************************************************************
	// initiator sequencing
	// ****************************************************************
	assign busIdle = frameNIn && irdyNIn;
	assign parkNow = (state == ST_IDLE) && !gntN && busIdle && !reqValid;
	assign transfer = (state == ST_DATA) && !trdyNIn;
	assign stopNow = (state == ST_DATA) && !stopNIn;
	assign abortNow = (state == ST_DATA) && devselNIn && !devselSeen
		&& (devselCnt == DEVSEL_LIMIT);
	assign reqReady = (state == ST_IDLE);

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (reqValid) begin
					next_state = ST_REQ;
				end
			end
			ST_REQ: begin
				if (!gntN && busIdle) begin
					next_state = ST_ADDR;
				end
			end
			ST_ADDR: begin
				next_state = ST_DATA;
			end
			ST_DATA: begin
				// irdy is never withdrawn before one of these ends the phase
				if (transfer || stopNow || abortNow) begin
					next_state = ST_END;
				end
			end
			ST_END: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrReg <= 1'b0;
			cmdReg <= CBE_PARK;
			beReg <= CBE_PARK;
			addrReg <= AD_PARK;
			dataReg <= AD_PARK;
		end else if ((state == ST_IDLE) && reqValid) begin
			wrReg <= reqWrite;
			cmdReg <= reqCmd;
			beReg <= reqByteEnN;
			addrReg <= reqAddr;
			dataReg <= reqData;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			firstData <= 1'b0;
		end else begin
			firstData <= (state == ST_ADDR);
		end
	end

	// counts clocks since frame start; cycle 1 is the first data clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			devselCnt <= CNT_ZERO;
			devselSeen <= 1'b0;
		end else if (state == ST_ADDR) begin
			devselCnt <= CNT_ONE;
			devselSeen <= 1'b0;
		end else if (state == ST_DATA) begin
			if (devselCnt != DEVSEL_LIMIT) begin
				devselCnt <= devselCnt + CNT_ONE;
			end
			if (!devselNIn) begin
				devselSeen <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// bus drive
	// ****************************************************************
	assign reqN = (state != ST_REQ);
	// single data phase, so frame goes high in the first data clock
	assign frameNOe = (state == ST_ADDR) || ((state == ST_DATA) && firstData);
	assign frameNOut = (state != ST_ADDR);
	assign irdyNOe = (state == ST_DATA) || (state == ST_END);
	assign irdyNOut = (state != ST_DATA);
	// reads turn ad around in the first data clock
	assign adOe = (state == ST_ADDR) || ((state == ST_DATA) && wrReg) || parkNow;
	assign adOut = (state == ST_ADDR) ? addrReg :
		((state == ST_DATA) ? dataReg : AD_PARK);
	assign cbeNOe = (state == ST_ADDR) || (state == ST_DATA) || parkNow;
	assign cbeNOut = (state == ST_ADDR) ? cmdReg :
		((state == ST_DATA) ? beReg : CBE_PARK);

	// parity follows whatever we put on ad one clock before
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			parOut <= 1'b0;
			parOe <= 1'b0;
		end else begin
			parOut <= ^{adOut, cbeNOut};
			parOe <= adOe;
		end
	end

	// ****************************************************************
	// parity checking and perr
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frameDly <= 1'b1;
		end else begin
			frameDly <= frameNIn;
		end
	end

	// target side perr for writes lives in the target path, not here
	assign sampleData = transfer && !wrReg;
	assign sampleAddr = !frameNIn && frameDly && (state != ST_ADDR);
	assign pc.ad = adIn;
	assign pc.cbeN = cbeNIn;
	assign pc.par = parIn;
	assign pc.sample = sampleData || sampleAddr;
	assign pc.isAddr = sampleAddr;

	parity_checker u_chk (
		.clk(clk),
		.rst_n(rst_n),
		.pc(pc.chk)
	);

	assign perrAssert = pc.dataErr && parityRespEn;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			perrHold <= 1'b0;
		end else begin
			perrHold <= perrAssert;
		end
	end

	assign perrNOe = perrAssert || perrHold;
	assign perrNOut = !perrAssert;

	// ****************************************************************
	// system error
	// ****************************************************************
	serr_gate u_serr (
		.clk(clk),
		.rst_n(rst_n),
		.srcEvent({serrExtEvent, pc.addrErr}),
		.srcEnable(serrSrcEnable),
		.serrEnable(serrEnable),
		.serrDrive(serrDrive)
	);

	// open drain: only ever pulls low
	assign serrNOut = SERR_LOW;
	assign serrNOe = serrDrive;

	// ****************************************************************
	// user side status
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData <= AD_PARK;
			rdValid <= 1'b0;
		end else begin
			rdValid <= sampleData;
			if (sampleData) begin
				rdData <= adIn;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xferDone <= 1'b0;
			masterAbort <= 1'b0;
			targetStop <= 1'b0;
		end else begin
			xferDone <= transfer;
			masterAbort <= abortNow;
			targetStop <= stopNow;
		end
	end

	// target perr for our write shows two clocks after the data clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrXfer1 <= 1'b0;
			wrXfer2 <= 1'b0;
			perrReported <= 1'b0;
		end else begin
			wrXfer1 <= transfer && wrReg;
			wrXfer2 <= wrXfer1;
			perrReported <= wrXfer2 && !perrNIn;
		end
	end

	assign dataParityErr = pc.dataErr;
	assign addrParityErr = pc.addrErr;

	// ****************************************************************
	// checks
	// ****************************************************************
	a_irdy_hold: assert property (@(posedge clk) disable iff (!rst_n)
		irdyNOe && !irdyNOut && trdyNIn && stopNIn && !abortNow |=> irdyNOe && !irdyNOut)
		else $error("irdy withdrawn before the data phase ended");
	a_irdy_release: assert property (@(posedge clk) disable iff (!rst_n)
		irdyNOe && irdyNOut |-> $past(irdyNOe && !irdyNOut) ##1 !irdyNOe)
		else $error("irdy not driven high for exactly one clock");
	a_par_value: assert property (@(posedge clk) disable iff (!rst_n)
		adOe |=> parOe && (parOut == ^$past({adOut, cbeNOut})))
		else $error("par wrong or late after driven ad");
	a_par_release: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(adOe) |-> parOe ##1 !parOe)
		else $error("par not released one clock after ad");
	a_park: assert property (@(posedge clk) disable iff (!rst_n)
		parkNow |-> adOe && cbeNOe && (adOut == AD_PARK) ##1 parOe)
		else $error("bus not parked under grant");
	a_write_data: assert property (@(posedge clk) disable iff (!rst_n)
		!irdyNOut && irdyNOe && wrReg |-> adOe && (adOut == dataReg))
		else $error("irdy on a write without data on ad");
	a_perr_timing: assert property (@(posedge clk) disable iff (!rst_n)
		sampleData && parityRespEn ##1 (parIn != ^$past({adIn, cbeNIn})) ##1 parityRespEn
		|-> perrNOe && !perrNOut ##1 perrNOe)
		else $error("perr missing two clocks after bad read data");
	a_master_abort: assert property (@(posedge clk) disable iff (!rst_n)
		(state == ST_ADDR) ##1 (devselNIn && stopNIn) [*5] |=> masterAbort ##1 !irdyNOe)
		else $error("no master abort after five clocks without devsel");
	a_req_out: assert property (@(posedge clk) disable iff (!rst_n)
		reqValid && reqReady |=> !reqN)
		else $error("bus request not raised for a pending transaction");

	c_write_done: cover property (@(posedge clk) disable iff (!rst_n) xferDone && wrReg);
	c_read_done: cover property (@(posedge clk) disable iff (!rst_n) rdValid);
	c_abort: cover property (@(posedge clk) disable iff (!rst_n) masterAbort);
	c_perr: cover property (@(posedge clk) disable iff (!rst_n) perrNOe && !perrNOut);
	c_serr_seen: cover property (@(posedge clk) disable iff (!rst_n) serrNOe && !serrNIn);
endmodule : pci_primary_port
`default_nettype wire

// >>> rtl/pci_pri_pkg.sv
// constants, types and state codes for the primary bus port
// assumes the whole port runs on the primary bus clock
package pci_pri_pkg;
	// ****************************************************************
	// bus widths and park values
	// ****************************************************************
	localparam int AD_W = 32;
	localparam int CBE_W = 4;
	localparam logic [AD_W-1:0] AD_PARK = 32'h0000_0000;
	localparam logic [CBE_W-1:0] CBE_PARK = 4'h0;
	localparam logic SERR_LOW = 1'b0;
	// ****************************************************************
	// timing
	// ****************************************************************
	// clocks after frame start that a target has to claim the cycle
	localparam logic [2:0] DEVSEL_LIMIT = 3'h5;
	localparam logic [2:0] CNT_ONE = 3'h1;
	localparam logic [2:0] CNT_ZERO = 3'h0;
	// ****************************************************************
	// system error sources, bit positions
	// ****************************************************************
	localparam int SERR_SRC_W = 8;
	localparam int SRC_ADDR_PAR = 0;
	localparam int SRC_SEC_DPAR = 1;
	localparam int SRC_MABORT_PW = 2;
	localparam int SRC_TABORT_PW = 3;
	localparam int SRC_DISCARD_PW = 4;
	localparam int SRC_DISCARD_DR = 5;
	localparam int SRC_DT_TIMEOUT = 6;
	localparam int SRC_SEC_SERR = 7;
	// ****************************************************************
	// initiator states
	// ****************************************************************
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_REQ = 5'h02,
		ST_ADDR = 5'h04,
		ST_DATA = 5'h08,
		ST_END = 5'h10
	} initState_t;
endpackage : pci_pri_pkg

// >>> rtl/parity_check_if.sv
// bundle between the port and its parity checker
// assumes both ends share the primary clock
`timescale 1ns/10ps
`default_nettype none
interface parity_check_if;
	import pci_pri_pkg::*;
	logic [AD_W-1:0] ad;
	logic [CBE_W-1:0] cbeN;
	logic par;
	logic sample;
	logic isAddr;
	logic dataErr;
	logic addrErr;
	modport chk(input ad, input cbeN, input par, input sample, input isAddr,
		output dataErr, output addrErr);
	modport host(output ad, output cbeN, output par, output sample, output isAddr,
		input dataErr, input addrErr);
endinterface : parity_check_if
`default_nettype wire

// >>> rtl/parity_checker.sv
// even parity checker for received address or data phases
// assumes sample marks the cycle in which ad and cbe are valid on the bus
`timescale 1ns/10ps
`default_nettype none
module parity_checker
	import pci_pri_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	parity_check_if.chk pc
);
	logic [AD_W-1:0] adReg;
	logic [CBE_W-1:0] cbeReg;
	logic pend;
	logic pendAddr;
	logic mismatch;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			adReg <= AD_PARK;
			cbeReg <= CBE_PARK;
		end else if (pc.sample) begin
			adReg <= pc.ad;
			cbeReg <= pc.cbeN;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend <= 1'b0;
			pendAddr <= 1'b0;
		end else begin
			pend <= pc.sample;
			pendAddr <= pc.sample && pc.isAddr;
		end
	end

	// par arrives one clock after the values it covers
	assign mismatch = pend && ((^{adReg, cbeReg}) != pc.par);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc.dataErr <= 1'b0;
			pc.addrErr <= 1'b0;
		end else begin
			pc.dataErr <= mismatch && !pendAddr;
			pc.addrErr <= mismatch && pendAddr;
		end
	end

	a_chk_compare: assert property (@(posedge clk) disable iff (!rst_n)
		pc.sample && !pc.isAddr ##1 (pc.par != ^$past({pc.ad, pc.cbeN}))
		|=> pc.dataErr && !pc.addrErr)
		else $error("data parity mismatch not flagged");
	a_chk_addr_kind: assert property (@(posedge clk) disable iff (!rst_n)
		pc.sample && pc.isAddr ##1 (pc.par != ^$past({pc.ad, pc.cbeN}))
		|=> pc.addrErr && !pc.dataErr)
		else $error("address parity mismatch not flagged");
endmodule : parity_checker
`default_nettype wire

// >>> rtl/serr_gate.sv
// enable gating of system error sources onto the open-drain drive
// assumes source events are one-cycle pulses on the primary clock
`timescale 1ns/10ps
`default_nettype none
module serr_gate
	import pci_pri_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [SERR_SRC_W-1:0] srcEvent,
	input wire logic [SERR_SRC_W-1:0] srcEnable,
	input wire logic serrEnable,
	output logic serrDrive
);
	logic fire;

	assign fire = serrEnable && (|(srcEvent & srcEnable));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			serrDrive <= 1'b0;
		end else begin
			serrDrive <= fire;
		end
	end

	a_serr_gated: assert property (@(posedge clk) disable iff (!rst_n)
		serrDrive |-> $past(serrEnable) && (|$past(srcEvent & srcEnable)))
		else $error("system error driven without an enabled source");
	a_serr_fires: assert property (@(posedge clk) disable iff (!rst_n)
		serrEnable && (|(srcEvent & srcEnable)) |=> serrDrive)
		else $error("enabled system error source did not drive the line");
endmodule : serr_gate
`default_nettype wire

// >>> test/pci_far_agent.sv
// behavioural arbiter and single-phase target on the primary bus
// assumes the bench resolves every wire from all parties' enables
`timescale 1ns/10ps
`default_nettype none
module pci_far_agent
	import pci_pri_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reqN,
	input wire logic frameN,
	input wire logic irdyN,
	input wire logic [AD_W-1:0] ad,
	input wire logic [CBE_W-1:0] cbeN,
	input wire logic par,
	input wire logic parkGnt,
	input wire logic [3:0] gntDelay,
	input wire logic [3:0] devDly,
	input wire logic badPar,
	input wire logic forcePerr,
	input wire logic [AD_W-1:0] rdWord,
	output logic gntN,
	output logic devselN,
	output logic trdyN,
	output logic [AD_W-1:0] tAd,
	output logic tAdOe,
	output logic tPar,
	output logic tParOe,
	output logic tPerrN,
	output logic tPerrOe
);
	logic [3:0] gntCnt;
	logic [3:0] cnt;
	logic act;
	logic isWr;
	logic chk;
	logic expPar;
	logic prevFrameN;
	logic fall;
	assign fall = prevFrameN && !frameN;
	// ****************
	// arbiter and target
	// ****************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{gntN, devselN, trdyN, tPerrN, prevFrameN} <= 5'h1f;
			{tAdOe, tParOe, tPerrOe, act, chk, isWr, expPar, tPar} <= 8'h00;
			gntCnt <= 4'h0;
			cnt <= 4'h0;
			tAd <= 32'h0;
		end else begin
			gntCnt <= reqN ? 4'h0 : gntCnt + 4'h1;
			gntN <= !(parkGnt || (!reqN && gntCnt >= gntDelay));
			prevFrameN <= frameN;
			tParOe <= tAdOe;
			tPar <= (^{tAd, cbeN}) ^ badPar;
			if (fall) begin
				act <= 1'b1;
				cnt <= 4'h1;
				isWr <= cbeN[0];
			end else if (act) begin
				cnt <= cnt + 4'h1;
				// a silent target never claims: drop out before the count wraps
				if (cnt == 4'he) act <= 1'b0;
			end
			if ((fall && devDly == 4'h1) || (act && cnt + 4'h1 == devDly)) begin
				devselN <= 1'b0;
				trdyN <= 1'b0;
				tAdOe <= !(fall ? cbeN[0] : isWr);
				tAd <= rdWord;
			end
			chk <= 1'b0;
			if (!trdyN && !irdyN) begin
				{devselN, trdyN} <= 2'b11;
				tAdOe <= 1'b0;
				act <= 1'b0;
				chk <= isWr;
				expPar <= ^{ad, cbeN};
			end
			if (chk && (par != expPar || forcePerr)) begin
				tPerrOe <= 1'b1;
				tPerrN <= 1'b0;
			end else if (tPerrOe && !tPerrN) tPerrN <= 1'b1;
			else tPerrOe <= 1'b0;
		end
	end
endmodule : pci_far_agent
`default_nettype wire

// >>> test/testbench.sv
// scenario bench for the primary bus port against the far agent model
// assumes one 200MHz clock; bench resolves the shared wires
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import pci_pri_pkg::*;
	logic clk, rst_n, reqValid, reqWrite, parityRespEn, serrEnable, reqReady, rdValid, xferDone;
	logic [CBE_W-1:0] reqCmd, reqByteEnN, cbeNOut, cbeW, fCbe, fltC;
	logic [AD_W-1:0] reqAddr, reqData, rdData, adOut, adW, tAd, fAd, flt, rdWord;
	logic [SERR_SRC_W-1:0] serrSrcEnable;
	logic [SERR_SRC_W-1:1] serrExtEvent;
	logic masterAbort, targetStop, dataParityErr, addrParityErr, perrReported, adOe, cbeNOe;
	logic parOut, parOe, frameNOut, frameNOe, irdyNOut, irdyNOe, reqN, gntN, perrNOut, perrNOe;
	logic serrNOut, serrNOe, devselN, trdyN, tAdOe, tPar, tParOe, tPerrN, tPerrOe, fAdOe;
	logic fFrameN, fPar, fParOe, parW, fltP, frameW, irdyW, parkGnt, badPar, forcePerr;
	logic pAdOe, pPar, started, dpeSeen, repSeen, stopN;
	logic [3:0] gntDelay, devDly;
	int err_count, checked;
	assign adW = adOe ? adOut : tAdOe ? tAd : fAdOe ? fAd : flt;
	assign cbeW = cbeNOe ? cbeNOut : fAdOe ? fCbe : fltC;
	assign parW = parOe ? parOut : tParOe ? tPar : fParOe ? fPar : fltP;
	assign frameW = frameNOe ? frameNOut : fFrameN;
	assign irdyW = irdyNOe ? irdyNOut : 1'b1;
	pci_primary_port u_pci_primary_port (.clk, .rst_n, .reqValid, .reqReady, .reqWrite, .reqCmd,
		.reqAddr, .reqByteEnN, .reqData, .rdData, .rdValid, .xferDone, .masterAbort, .targetStop,
		.dataParityErr, .addrParityErr, .perrReported, .parityRespEn, .serrEnable,
		.serrSrcEnable, .serrExtEvent, .adIn(adW), .adOut, .adOe, .cbeNIn(cbeW), .cbeNOut,
		.cbeNOe, .parIn(parW), .parOut, .parOe, .frameNIn(frameW), .frameNOut, .frameNOe,
		.irdyNIn(irdyW), .irdyNOut, .irdyNOe, .trdyNIn(trdyN), .devselNIn(devselN),
		.stopNIn(stopN), .gntN, .reqN, .perrNIn(perrNOe ? perrNOut : tPerrOe ? tPerrN : 1'b1),
		.perrNOut, .perrNOe, .serrNIn(serrNOe ? serrNOut : 1'b1), .serrNOut, .serrNOe);
	pci_far_agent u_pci_far_agent (.clk, .rst_n, .reqN, .frameN(frameW), .irdyN(irdyW),
		.ad(adW), .cbeN(cbeW), .par(parW), .parkGnt, .gntDelay, .devDly, .badPar, .forcePerr,
		.rdWord, .gntN, .devselN, .trdyN, .tAd, .tAdOe, .tPar, .tParOe, .tPerrN, .tPerrOe);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// released lines without a pull-up show the inverse of their last level
	always @(posedge clk) begin
		flt <= ~adW;
		fltC <= ~cbeW;
		fltP <= ~parW;
	end
	// ****************
	// helpers
	// ****************
	task automatic check(input string name, input logic [AD_W-1:0] seen, input logic [AD_W-1:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wrap_up;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up
	task automatic tick;
		@(posedge clk);
		#1;
	endtask : tick
	function automatic logic sigOf(input int s);
		case (s)
			0: return xferDone;
			1: return rdValid;
			default: return irdyNOe && !irdyNOut;
		endcase
	endfunction : sigOf
	task automatic waitFor(input int s);
		int i;
		for (i = 0; i < 40 && sigOf(s) !== 1'b1; i++) tick();
		if (i == 40) begin
			err_count++;
			$display("[FAIL] wait %0d expected 1 seen timeout", s);
			wrap_up();
		end
	endtask : waitFor
	// parity follows our own drive of the previous clock
	always @(negedge clk) begin
		if (!rst_n) started = 1'b0;
		else begin
			if (started) check("parOe", parOe, pAdOe);
			if (started && pAdOe) check("parOut", parOut, pPar);
			pAdOe = adOe;
			pPar = ^{adOut, cbeNOut};
			started = 1'b1;
			if (dataParityErr === 1'b1) dpeSeen = 1'b1;
			if (perrReported === 1'b1) repSeen = 1'b1;
		end
	end
	task automatic issue(input logic wr, input logic [AD_W-1:0] addr, input logic [AD_W-1:0] data);
		int i;
		reqWrite = wr;
		reqCmd = wr ? 4'h7 : 4'h6;
		reqByteEnN = wr ? 4'h5 : 4'h0;
		reqAddr = addr;
		reqData = data;
		reqValid = 1'b1;
		for (i = 0; i < 20 && reqReady !== 1'b1; i++) tick();
		if (i == 20) begin
			err_count++;
			$display("[FAIL] reqReady expected 1 seen timeout");
			wrap_up();
		end
		tick();
		reqValid = 1'b0;
	endtask : issue
	// ****************
	// scenarios
	// ****************
	task automatic t_write;
		gntDelay = 4'h4;
		devDly = 4'h2;
		forcePerr = 1'b1;
		repSeen = 1'b0;
		issue(1'b1, 32'h1000_0040, 32'hdead_beef);
		check("reqN", reqN, 1'b0);
		tick();
		check("reqN", reqN, 1'b0);
		waitFor(2);
		check("adOe", adOe, 1'b1);
		check("adOut", adOut, 32'hdead_beef);
		check("cbeNOut", cbeNOut, 4'h5);
		check("frameEnd", {frameNOe, frameNOut}, 2'b11);
		tick();
		check("irdyHeld", irdyNOut, 1'b0);
		check("frameOe", frameNOe, 1'b0);
		waitFor(0);
		check("irdyEnd", {irdyNOe, irdyNOut}, 2'b11);
		tick();
		check("irdyOe", irdyNOe, 1'b0);
		repeat (4) tick();
		check("perrReported", repSeen, 1'b1);
		forcePerr = 1'b0;
	endtask : t_write
	task automatic t_read(input logic bad, input logic resp);
		int k;
		logic [1:0] seq [3] = '{2'b10, 2'b11, 2'b00};
		badPar = bad;
		parityRespEn = resp;
		dpeSeen = 1'b0;
		devDly = 4'h1;
		rdWord = {31'h2d2d_0787, bad};
		issue(1'b0, 32'h2000_0000, 32'h0);
		waitFor(2);
		check("adOeRead", adOe, 1'b0);
		waitFor(1);
		check("rdData", rdData, rdWord);
		for (k = 0; k < 3; k++) begin
			tick();
			check("perr", perrNOe ? {1'b1, perrNOut} : 2'b00, (bad & resp) ? seq[k] : 2'b00);
		end
		check("dataParityErr", dpeSeen, bad);
		badPar = 1'b0;
	endtask : t_read
	task automatic t_abort;
		int n;
		devDly = 4'h0;
		issue(1'b1, 32'h3000_0000, 32'h1234_5678);
		waitFor(2);
		for (n = 0; n < 8 && masterAbort !== 1'b1; n++) begin
			check("irdyHeld", irdyNOut, 1'b0);
			tick();
		end
		check("abortCycle", n, 5);
		check("irdyEnd", {irdyNOe, irdyNOut}, 2'b11);
		repeat (2) tick();
	endtask : t_abort
	// target stop with no claim: ends the phase without a transfer
	task automatic t_stop;
		devDly = 4'h0;
		issue(1'b1, 32'h5000_0000, 32'h0f0f_0f0f);
		waitFor(2);
		stopN = 1'b0;
		tick();
		stopN = 1'b1;
		check("targetStop", targetStop, 1'b1);
		check("stopNoXfer", xferDone, 1'b0);
		check("irdyEnd", {irdyNOe, irdyNOut}, 2'b11);
		tick();
		check("irdyOe", irdyNOe, 1'b0);
	endtask : t_stop
	task automatic t_park;
		parkGnt = 1'b1;
		repeat (3) tick();
		check("parkOe", {adOe, cbeNOe}, 2'b11);
		check("parkAd", {adOut, cbeNOut}, {AD_PARK, CBE_PARK});
		check("parkPar", {parOe, parOut}, {1'b1, ^{AD_PARK, CBE_PARK}});
		parkGnt = 1'b0;
		repeat (3) tick();
	endtask : t_park
	task automatic t_addr;
		serrEnable = 1'b1;
		serrSrcEnable = 8'h01;
		fAd = 32'h4000_0010;
		fCbe = 4'h6;
		fAdOe = 1'b1;
		fFrameN = 1'b0;
		tick();
		fAdOe = 1'b0;
		fFrameN = 1'b1;
		fPar = ~^{fAd, fCbe};
		fParOe = 1'b1;
		tick();
		fParOe = 1'b0;
		check("addrParityErr", addrParityErr, 1'b1);
		tick();
		check("serrAddr", {serrNOe, serrNOut}, {1'b1, SERR_LOW});
		tick();
		check("serrOnce", serrNOe, 1'b0);
	endtask : t_addr
	task automatic pulse(input int s, input logic [SERR_SRC_W-1:0] en, input logic master);
		serrSrcEnable = en;
		serrEnable = master;
		serrExtEvent = '0;
		serrExtEvent[s] = 1'b1;
		tick();
		serrExtEvent = '0;
		check("serrDrive", serrNOe, en[s] & master);
		if (serrNOe === 1'b1) check("serrLevel", serrNOut, SERR_LOW);
		tick();
		check("serrRelease", serrNOe, 1'b0);
	endtask : pulse
	initial begin
		{rst_n, reqValid, reqWrite, serrEnable, parkGnt, badPar, forcePerr} = 7'h0;
		{fAdOe, fPar, fParOe, flt, fltC, fltP, fAd, fCbe, rdWord} = '0;
		{reqCmd, reqByteEnN, reqAddr, reqData, serrSrcEnable, serrExtEvent} = '0;
		{fFrameN, parityRespEn, stopN, dpeSeen, repSeen} = 5'h1c;
		gntDelay = 4'h0;
		devDly = 4'h1;
		err_count = 0;
		checked = 0;
		repeat (10) @(posedge clk);
		#1;
		check("resetReqN", reqN, 1'b1);
		rst_n = 1'b1;
		tick();
		t_write();
		t_read(1'b0, 1'b1);
		t_read(1'b1, 1'b1);
		t_read(1'b1, 1'b0);
		t_abort();
		t_stop();
		t_park();
		t_addr();
		for (int s = 1; s < SERR_SRC_W; s++) begin
			pulse(s, 8'hff, 1'b1);
			pulse(s, ~(8'h01 << s), 1'b1);
		end
		pulse(3, 8'hff, 1'b0);
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
